// >>> rtl/temp_limit_i2c_slave_regs.v
/*
 * Two-wire slave and limit register set of a temperature sensor: pointer, high/low/
 * critical limits, hysteresis, identification, limit comparison to alarm outputs.
 * Assumes scl/sda/address-select come from pins; temp_value/temp_valid come from the
 * conversion engine on clk. SDA is open drain: the wire is low while sda_oe_n is low.
 */
// What this block does
// - above high limit sets overtemperature flag and alarm output.
// - below low limit sets undertemperature flag and alarm output.
// - above critical limit drives the critical output.
// - limits are 16-bit two's complement, upper byte at lower address.
// - high limit reads upper byte at 0x04 then lower at 0x05.
// - low limit reads upper byte at 0x06 then lower at 0x07.
// - critical limit reads upper byte at 0x08 then lower at 0x09.
// - limit defaults 0x2000, 0x0500 and 0x4980.
// - hysteresis is 4-bit unsigned, 0 to 15 degrees, upper bits unused.
// - hysteresis lowers high/critical release points and raises low release point.
// - hysteresis resets to five; bits 7..4 read as unused zeros.
// - identification register is read-only: maker code and revision code.
// - bus address is 10010 plus the two address-select pins.
// - after START, eight bits: address MSB first then direction.
// - acknowledge own address by pulling SDA low, else idle.
// - direction 0 means master writes, 1 means master reads.
// - nine clocks per byte; SDA changes only while SCL low.
// - direction fixed by address byte until a new START.
// - limits accept upper then lower byte in one write.
// - pointer loads 0x00 at power-up.
// - extra written data bytes are discarded.
// - reads auto-increment only from upper to lower byte of 16-bit registers.
// - pointer 0x2F then STOP restores defaults; no acknowledge for 200 us.
`timescale 1ns/1ps
`include "temp_limit_consts.vh"

module temp_limit_i2c_slave_regs #(
  parameter [4:0] MAKER_CODE = 5'h0A,   // arbitrary value
  parameter [2:0] REVISION_CODE = 3'h2, // arbitrary value
  parameter SW_RESET_CYCLES = `SW_RESET_US * `CLK_FREQ_MHZ
) (
  input wire clk,
  input wire arst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire addr_select_bit0,
  input wire addr_select_bit1,
  input wire [15:0] temp_value,
  input wire temp_valid,
  output reg alarm_out,
  output reg critical_out,
  output reg over_flag,
  output reg under_flag,
  output reg reset_busy
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ADDR_ACK = 3'h2;
  localparam [2:0] ST_WR_DATA = 3'h3;
  localparam [2:0] ST_WR_ACK = 3'h4;
  localparam [2:0] ST_RD_DATA = 3'h5;
  localparam [2:0] ST_RD_ACK = 3'h6;
  localparam [31:0] RST_CNT_FULL = SW_RESET_CYCLES;
  localparam [15:0] RST_CNT = RST_CNT_FULL[15:0];

  // ==========================================================
  // pin synchronisation and bus conditions
  wire scl_s;
  wire sda_s;
  wire [1:0] asel_s;
  reg scl_prev_q;
  reg sda_prev_q;

  bit_sync #(.W(2), .INIT(2'b11)) u_bus_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({scl_in, sda_in}),
    .q({scl_s, sda_s})
  );

  bit_sync #(.W(2), .INIT(2'b00)) u_asel_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({addr_select_bit1, addr_select_bit0}),
    .q(asel_s)
  );

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ==========================================================
  // registers
  reg [7:0] ptr_q;
  reg [7:0] high_up_q;
  reg [7:0] high_lo_q;
  reg [7:0] low_up_q;
  reg [7:0] low_lo_q;
  reg [7:0] crit_up_q;
  reg [7:0] crit_lo_q;
  reg [`HYST_W-1:0] hyst_q;
  reg [15:0] temp_q;
  reg eval_q;
  reg [15:0] busy_cnt_q;

  // ==========================================================
  // slave state
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [1:0] byte_idx_q;
  reg rw_q;
  reg ack_q;
  reg drive_q;
  reg soft_pend_q;

  wire addr_hit = (shift_q[7:1] == {`BUS_ADDR_FIXED, asel_s}) && (busy_cnt_q == 16'h0000);
  // only upper bytes of limits take a second data byte
  wire ptr_is_limit_up = (ptr_q == `REG_HIGH_UPPER) || (ptr_q == `REG_LOW_UPPER) ||
                         (ptr_q == `REG_CRIT_UPPER);
  // two-byte registers whose upper byte moves the pointer on
  wire ptr_auto_inc = ptr_is_limit_up || (ptr_q == `REG_TEMP_UPPER);

  // read data for the current pointer
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (ptr_q)
      `REG_TEMP_UPPER: rd_byte = temp_q[15:8];
      `REG_TEMP_LOWER: rd_byte = temp_q[7:0];
      `REG_HIGH_UPPER: rd_byte = high_up_q;
      `REG_HIGH_LOWER: rd_byte = high_lo_q;
      `REG_LOW_UPPER: rd_byte = low_up_q;
      `REG_LOW_LOWER: rd_byte = low_lo_q;
      `REG_CRIT_UPPER: rd_byte = crit_up_q;
      `REG_CRIT_LOWER: rd_byte = crit_lo_q;
      `REG_HYST: rd_byte = {{(8 - `HYST_W){1'b0}}, hyst_q};
      `REG_IDENT: rd_byte = {MAKER_CODE, REVISION_CODE};
      default: rd_byte = 8'h00;
    endcase
  end

  // write target: second data byte goes to the lower byte
  wire wr_en = (state_q == ST_WR_DATA) && scl_fall && (bit_cnt_q == 4'h8) &&
               ((byte_idx_q == 2'h1) || ((byte_idx_q == 2'h2) && ptr_is_limit_up));
  wire [7:0] wr_addr = (byte_idx_q == 2'h2) ? (ptr_q + 8'h01) : ptr_q;
  wire soft_reset = stop_det && soft_pend_q;

  // ==========================================================
  // register file
  // limit power-on values
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      high_up_q <= `RST_HIGH_UPPER;
      high_lo_q <= `RST_HIGH_LOWER;
      low_up_q <= `RST_LOW_UPPER;
      low_lo_q <= `RST_LOW_LOWER;
      crit_up_q <= `RST_CRIT_UPPER;
      crit_lo_q <= `RST_CRIT_LOWER;
      hyst_q <= `RST_HYST;
      busy_cnt_q <= 16'h0000;
    end else if (soft_reset) begin
      high_up_q <= `RST_HIGH_UPPER;
      high_lo_q <= `RST_HIGH_LOWER;
      low_up_q <= `RST_LOW_UPPER;
      low_lo_q <= `RST_LOW_LOWER;
      crit_up_q <= `RST_CRIT_UPPER;
      crit_lo_q <= `RST_CRIT_LOWER;
      hyst_q <= `RST_HYST;
      busy_cnt_q <= RST_CNT;
    end else begin
      if (busy_cnt_q != 16'h0000) begin
        busy_cnt_q <= busy_cnt_q - 16'h0001;
      end
      if (wr_en) begin
        case (wr_addr)
          `REG_HIGH_UPPER: high_up_q <= shift_q;
          `REG_HIGH_LOWER: high_lo_q <= shift_q;
          `REG_LOW_UPPER: low_up_q <= shift_q;
          `REG_LOW_LOWER: low_lo_q <= shift_q;
          `REG_CRIT_UPPER: crit_up_q <= shift_q;
          `REG_CRIT_LOWER: crit_lo_q <= shift_q;
          `REG_HYST: hyst_q <= shift_q[`HYST_W-1:0];
          default: hyst_q <= hyst_q;
        endcase
      end
    end
  end

  // ==========================================================
  // slave sequencer
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      byte_idx_q <= 2'h0;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      drive_q <= 1'b0;
      soft_pend_q <= 1'b0;
      ptr_q <= `RST_POINTER;
    end else if (start_det) begin
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      drive_q <= 1'b0;
      soft_pend_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      drive_q <= 1'b0;
      soft_pend_q <= 1'b0;
      if (soft_pend_q) begin
        ptr_q <= `RST_POINTER;
      end
    end else begin
      case (state_q)
        ST_ADDR, ST_WR_DATA: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && (bit_cnt_q == 4'h8)) begin
            if (state_q == ST_ADDR) begin
              if (addr_hit) begin
                drive_q <= 1'b1;
                rw_q <= shift_q[0];
                byte_idx_q <= 2'h0;
                state_q <= ST_ADDR_ACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end else begin
              // first data byte loads the pointer
              if (byte_idx_q == 2'h0) begin
                ptr_q <= shift_q;
                soft_pend_q <= (shift_q == `REG_SOFT_RESET);
              end else begin
                soft_pend_q <= 1'b0;
              end
              // bytes past the register are dropped
              if (byte_idx_q != 2'h3) begin
                byte_idx_q <= byte_idx_q + 2'h1;
              end
              drive_q <= 1'b1;
              state_q <= ST_WR_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (rw_q) begin
              tx_q <= rd_byte;
              drive_q <= ~rd_byte[7];
              if (ptr_auto_inc) begin
                ptr_q <= ptr_q + 8'h01;
              end
              state_q <= ST_RD_DATA;
            end else begin
              drive_q <= 1'b0;
              state_q <= ST_WR_DATA;
            end
          end
        end
        // write path never turns into a read
        ST_WR_ACK: begin
          if (scl_fall) begin
            drive_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            state_q <= ST_WR_DATA;
          end
        end
        ST_RD_DATA: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            // SDA moves only after SCL falls
            if (bit_cnt_q == 4'h8) begin
              drive_q <= 1'b0;
              state_q <= ST_RD_ACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              drive_q <= ~tx_q[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            ack_q <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (ack_q) begin
              tx_q <= rd_byte;
              drive_q <= ~rd_byte[7];
              if (ptr_auto_inc) begin
                ptr_q <= ptr_q + 8'h01;
              end
              state_q <= ST_RD_DATA;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // temperature capture and limit comparison
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_q <= 16'h0000;
      eval_q <= 1'b0;
    end else begin
      eval_q <= temp_valid;
      if (temp_valid) begin
        temp_q <= temp_value;
      end
    end
  end

  wire over_w;
  wire under_w;
  wire crit_w;

  limit_compare #(.ABOVE(1)) u_cmp_high (
    .clk(clk),
    .arst_n(arst_n),
    .eval(eval_q),
    .temp(temp_q),
    .limit({high_up_q, high_lo_q}),
    .hyst(hyst_q),
    .flag_q(over_w)
  );

  limit_compare #(.ABOVE(0)) u_cmp_low (
    .clk(clk),
    .arst_n(arst_n),
    .eval(eval_q),
    .temp(temp_q),
    .limit({low_up_q, low_lo_q}),
    .hyst(hyst_q),
    .flag_q(under_w)
  );

  limit_compare #(.ABOVE(1)) u_cmp_crit (
    .clk(clk),
    .arst_n(arst_n),
    .eval(eval_q),
    .temp(temp_q),
    .limit({crit_up_q, crit_lo_q}),
    .hyst(hyst_q),
    .flag_q(crit_w)
  );

  // ==========================================================
  // registered outputs
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      alarm_out <= 1'b0;
      critical_out <= 1'b0;
      over_flag <= 1'b0;
      under_flag <= 1'b0;
      reset_busy <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= ~drive_q;
      alarm_out <= over_w | under_w;
      critical_out <= crit_w;
      over_flag <= over_w;
      under_flag <= under_w;
      reset_busy <= (busy_cnt_q != 16'h0000);
    end
  end

endmodule

// >>> common/temp_limit_consts.vh
/*
 * Constants of the limit-checking register set: register offsets, power-on values,
 * bus address, hysteresis scaling and timing counts.
 * Assumes it is included by bare name from the rtl modules that need it.
 */
`ifndef TEMP_LIMIT_CONSTS_VH
`define TEMP_LIMIT_CONSTS_VH

// ==========================================================
// register offsets (pointer values)
`define REG_TEMP_UPPER 8'h00
`define REG_TEMP_LOWER 8'h01
`define REG_STATUS 8'h02
`define REG_CONFIG 8'h03
`define REG_HIGH_UPPER 8'h04
`define REG_HIGH_LOWER 8'h05
`define REG_LOW_UPPER 8'h06
`define REG_LOW_LOWER 8'h07
`define REG_CRIT_UPPER 8'h08
`define REG_CRIT_LOWER 8'h09
`define REG_HYST 8'h0A
`define REG_IDENT 8'h0B
`define REG_SOFT_RESET 8'h2F

// ==========================================================
// power-on values
`define RST_POINTER 8'h00
`define RST_HIGH_UPPER 8'h20
`define RST_HIGH_LOWER 8'h00
`define RST_LOW_UPPER 8'h05
`define RST_LOW_LOWER 8'h00
`define RST_CRIT_UPPER 8'h49
`define RST_CRIT_LOWER 8'h80
`define RST_HYST 4'h5

// ==========================================================
// fields and bus address
`define HYST_W 4
`define HYST_LSB 7
`define IDENT_MAKER_LSB 3
`define BUS_ADDR_FIXED 5'h12

// ==========================================================
// timing
`define CLK_FREQ_MHZ 50
`define SW_RESET_US 200

`endif

// >>> rtl/bit_sync.v
/*
 * Two-flop synchroniser for levels arriving from outside the clock domain.
 * Assumes the inputs are slow compared with clk; INIT is the idle level of each line.
 */
`timescale 1ns/1ps

module bit_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk,
  input wire arst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// >>> rtl/limit_compare.v
/*
 * One limit comparison with hysteresis, for an upper (ABOVE=1) or lower limit.
 * Assumes temp and limit are 16-bit two's complement with 1 degree at bit 7.
 */
`timescale 1ns/1ps
`include "temp_limit_consts.vh"

module limit_compare #(
  parameter ABOVE = 1
) (
  input wire clk,
  input wire arst_n,
  input wire eval,
  input wire [15:0] temp,
  input wire [15:0] limit,
  input wire [`HYST_W-1:0] hyst,
  output reg flag_q
);

  // two guard bits so limit +/- hysteresis cannot wrap
  wire signed [17:0] t = {{2{temp[15]}}, temp};
  wire signed [17:0] l = {{2{limit[15]}}, limit};
  wire signed [17:0] h = $signed({14'h0000, hyst}) <<< `HYST_LSB;
  wire signed [17:0] rel = (ABOVE != 0) ? (l - h) : (l + h);
  wire trip = (ABOVE != 0) ? (t > l) : (t < l);
  wire clear = (ABOVE != 0) ? (t < rel) : (t > rel);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= 1'b0;
    end else if (eval) begin
      if (trip) begin
        flag_q <= 1'b1;
      end else if (clear) begin
        flag_q <= 1'b0;
      end
    end
  end

endmodule

// >>> tb/i2c_master_model.sv
/* Behavioural bus master: drives the serial clock and pulls the data wire low.
   Assumes the bench resolves the data wire with a pull-up and feeds it back on sda. */
`timescale 1ns/1ps

module i2c_master_model (
  output reg scl,
  output reg pull_low,
  input wire sda
);
  initial begin
    scl = 1'h1;
    pull_low = 1'h0;
  end

  // ========
  // framing; called on a falling clk edge, so pin edges never meet a rising clk edge
  // start while clock high
  task start_cond;
    pull_low = 1'h0;
    #55 scl = 1'h1;
    #100 pull_low = 1'h1;
    #105 scl = 1'h0;
  endtask

  // data low then released with clock high
  task stop_cond;
    pull_low = 1'h1;
    #115 scl = 1'h1;
    #100 pull_low = 1'h0;
    #205;
  endtask

  // nine clocks, data moved only while clock low
  task xfer(input [7:0] tx, input ack_in, output [7:0] rx, output ack);
    integer i;
    for (i = 0; i < 9; i = i + 1) begin
      #25 pull_low = (i < 8) ? !tx[7 - i] : !ack_in;
      #90 scl = 1'h1;
      // sample late: slave data settles 70 ns after the fall, before the rise
      #40;
      if (i < 8) rx[7 - i] = sda;
      else ack = sda;
      #5 scl = 1'h0;
    end
  endtask
endmodule

// >>> tb/temp_limit_chk_chk.sv
/* Port checker of the limit register block: pin timing, alarm outputs, hold-off.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps

module temp_limit_chk (
  input wire clk,
  input wire arst_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire addr_select_bit0,
  input wire addr_select_bit1,
  input wire [15:0] temp_value,
  input wire temp_valid,
  input wire alarm_out,
  input wire critical_out,
  input wire over_flag,
  input wire under_flag,
  input wire reset_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ========
  // sequences
  sequence s_released;
    $rose(arst_n);
  endsequence
  sequence s_oe_move;
    $changed(sda_oe_n);
  endsequence

  // ========
  // properties
  property p_sda_zero;
    sda_out == 1'h0;
  endproperty
  property p_reset_out;
    s_released |-> sda_oe_n && !alarm_out && !critical_out && !reset_busy;
  endproperty
  property p_alarm_sum;
    alarm_out == (over_flag || under_flag);
  endproperty
  property p_over_cause;
    $changed(over_flag) |-> $past(temp_valid, 3);
  endproperty
  property p_under_cause;
    $changed(under_flag) |-> $past(temp_valid, 3);
  endproperty
  property p_crit_cause;
    $changed(critical_out) |-> $past(temp_valid, 3);
  endproperty
  property p_busy_quiet;
    reset_busy |-> sda_oe_n;
  endproperty
  property p_edge_low;
    s_oe_move |-> !scl_in;
  endproperty
  property p_ack_low;
    $fell(sda_oe_n) |-> !$past(scl_in, 2) && !$past(scl_in, 3);
  endproperty

  a_sda_zero: assert property (p_sda_zero)
    else $error("sda driven high");
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not idle after reset");
  a_alarm_sum: assert property (p_alarm_sum)
    else $error("alarm not over or under");
  a_over_cause: assert property (p_over_cause)
    else $error("over flag moved without new temperature");
  a_under_cause: assert property (p_under_cause)
    else $error("under flag moved without new temperature");
  a_crit_cause: assert property (p_crit_cause)
    else $error("critical moved without new temperature");
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("sda driven during hold-off");
  a_edge_low: assert property (p_edge_low)
    else $error("sda moved while scl high");
  a_ack_low: assert property (p_ack_low)
    else $error("sda pulled without scl low");
endmodule

bind temp_limit_i2c_slave_regs temp_limit_chk u_chk (
  .clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .addr_select_bit0(addr_select_bit0),
  .addr_select_bit1(addr_select_bit1), .temp_value(temp_value), .temp_valid(temp_valid),
  .alarm_out(alarm_out), .critical_out(critical_out), .over_flag(over_flag),
  .under_flag(under_flag), .reset_busy(reset_busy));

// >>> tb/tb.sv
/* Self-checking bench: registers over the bus model, alarms under random
   temperatures, software reset. Assumes model and checker are compiled first. */
`timescale 1ns/1ps
`include "temp_limit_consts.vh"

module tb;
  localparam [4:0] MK = 5'h15; // arbitrary value
  localparam [2:0] RV = 3'h5; // arbitrary value
  reg clk = 1'h0;
  reg arst_n = 1'h0;
  reg [1:0] sel = 2'h0;
  reg [15:0] temp = 16'h0000;
  reg tv = 1'h0;
  wire scl, pull_low, sda_out, sda_oe_n, alarm, crit, over, under, busy;
  wire sda = !(pull_low || !sda_oe_n);
  integer mismatches = 0;
  integer n_checks = 0;
  integer i, k;
  reg signed [15:0] hl, ll, cl, hy;
  reg [2:0] fl = 3'h0;
  reg [7:0] rx;
  reg ak;
  reg [15:0] v;
  reg [31:0] r;
  reg [15:0] cor [0:9];

  always #10 clk = !clk;

  i2c_master_model u_mst (.scl(scl), .pull_low(pull_low), .sda(sda));

  temp_limit_i2c_slave_regs #(.MAKER_CODE(MK), .REVISION_CODE(RV), .SW_RESET_CYCLES(200)) u_dut (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
    .temp_value(temp), .temp_valid(tv), .alarm_out(alarm), .critical_out(crit),
    .over_flag(over), .under_flag(under), .reset_busy(busy));

  // ========
  // checking
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input [15:0] e, input [15:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("mismatch %0s expected %h seen %h", nm, e, g);
    end
  endtask

  task wb(input [7:0] b, input ex);
    u_mst.xfer(b, 1'h1, rx, ak);
    chk("ack", {15'h0, ex}, {15'h0, ak});
  endtask

  task wr(input [7:0] p, input integer n, input [23:0] d);
    integer j;
    u_mst.start_cond;
    wb({`BUS_ADDR_FIXED, sel, 1'h0}, 1'h0);
    wb(p, 1'h0);
    for (j = n; j > 0; j = j - 1)
      wb(d[8*j-1 -: 8], 1'h0);
    u_mst.stop_cond;
  endtask

  // read starts afresh; pointer FF keeps the old pointer
  task rd(input [7:0] p, input integer n, input [15:0] e, input string nm);
    integer j;
    if (p != 8'hFF)
      wr(p, 0, 24'h0);
    u_mst.start_cond;
    wb({`BUS_ADDR_FIXED, sel, 1'h1}, 1'h0);
    v = 16'h0000;
    for (j = 1; j <= n; j = j + 1) begin
      u_mst.xfer(8'hFF, j == n, rx, ak);
      v = {v[7:0], rx};
    end
    u_mst.stop_cond;
    chk(nm, e, v);
  endtask

  function automatic [2:0] nxt(input [2:0] f, input signed [15:0] t);
    reg ov, un, cr;
    ov = (t > hl) ? 1'h1 : (t < hl - hy) ? 1'h0 : f[0];
    un = (t < ll) ? 1'h1 : (t > ll + hy) ? 1'h0 : f[1];
    cr = (t > cl) ? 1'h1 : (t < cl - hy) ? 1'h0 : f[2];
    nxt = {cr, un, ov};
  endfunction

  initial begin
    #1000000;
    mismatches = mismatches + 1;
    stop_test;
  end

  initial begin
    void'($urandom(26547));
    cor = '{16'h1001, 16'h1000, 16'h0F00, 16'h0EFF, 16'h07FF,
            16'h0900, 16'h0901, 16'hF000, 16'h1801, 16'h16FF};
    repeat (5) @(posedge clk);
    @(negedge clk) arst_n = 1'h1;
    repeat (4) @(negedge clk);
    rd(8'hFF, 1, 16'h0000, "ptr0");
    rd(`REG_HIGH_UPPER, 2, 16'h2000, "high");
    rd(`REG_LOW_UPPER, 2, 16'h0500, "low");
    rd(`REG_CRIT_UPPER, 2, 16'h4980, "crit");
    rd(`REG_HYST, 1, 16'h0005, "hyst");
    for (k = 0; k < 4; k = k + 1) begin
      @(negedge clk) sel = k[1:0];
      repeat (4) @(negedge clk);
      rd(`REG_IDENT, 1, {8'h00, MK, RV}, "ident");
      u_mst.start_cond;
      wb({`BUS_ADDR_FIXED, ~sel, 1'h0}, 1'h1);
      u_mst.stop_cond;
    end
    for (k = 0; k < 3; k = k + 1) begin
      r = $urandom;
      wr(8'h04 + {k[6:0], 1'h0}, 3, {r[15:0], 8'h5A});
      rd(8'h04 + {k[6:0], 1'h0}, 2, r[15:0], "limit");
    end
    rd(`REG_CRIT_UPPER, 3, {r[7:0], r[7:0]}, "repeat");
    wr(`REG_HYST, 2, 24'h00F703);
    rd(`REG_HYST, 2, 16'h0707, "hyst");
    wr(`REG_IDENT, 1, 24'h0000FF);
    rd(`REG_IDENT, 1, {8'h00, MK, RV}, "ident");
    hl = 16'h1000;
    ll = 16'h0800;
    cl = 16'h1800;
    hy = 16'h0100;
    wr(`REG_HIGH_UPPER, 2, {8'h00, hl});
    wr(`REG_LOW_UPPER, 2, {8'h00, ll});
    wr(`REG_CRIT_UPPER, 2, {8'h00, cl});
    wr(`REG_HYST, 1, 24'h000002);
    for (i = 0; i < 60; i = i + 1) begin
      r = $urandom_range(32'h1C00, 32'h0);
      if (i < 10)
        r = {16'h0, cor[i]};
      @(negedge clk);
      temp = r[15:0];
      tv = 1'h1;
      @(negedge clk);
      tv = 1'h0;
      fl = nxt(fl, r[15:0]);
      repeat (3) @(negedge clk);
      v = {12'h0, fl, fl[0] | fl[1]};
      chk("flags", v, {12'h0, crit, under, over, alarm});
    end
    rd(`REG_TEMP_UPPER, 2, r[15:0], "temp");
    wr(`REG_SOFT_RESET, 0, 24'h0);
    chk("busy", 16'h0001, {15'h0, busy});
    u_mst.start_cond;
    wb({`BUS_ADDR_FIXED, sel, 1'h0}, 1'h1);
    u_mst.stop_cond;
    k = 0;
    while (busy !== 1'h0 && k < 1000) begin
      @(negedge clk);
      k = k + 1;
    end
    chk("busy", 16'h0000, {15'h0, busy});
    rd(8'hFF, 2, r[15:0], "ptr0");
    rd(`REG_HIGH_UPPER, 2, 16'h2000, "high");
    rd(`REG_HYST, 1, 16'h0005, "hyst");
    stop_test;
  end
endmodule
